// ==== include/vdphp_regs.svh ====
// Constants of the video processor host port
`ifndef VDPHP_REGS_SVH
`define VDPHP_REGS_SVH
`define VDPHP_REG_MODE0 3'h0
`define VDPHP_REG_MODE1 3'h1
`define VDPHP_REG_NAME 3'h2
`define VDPHP_REG_COLOR 3'h3
`define VDPHP_REG_PATTERN 3'h4
`define VDPHP_REG_SPR_ATTR 3'h5
`define VDPHP_REG_SPR_PAT 3'h6
`define VDPHP_REG_TEXT_COL 3'h7
`define VDPHP_IRQ_EN_BIT 5
`define VDPHP_ST_FRAME_BIT 7
`define VDPHP_ST_FIFTH_BIT 6
`define VDPHP_ST_COLL_BIT 5
`define VDPHP_REG_RESET 8'h00
`define VDPHP_MAX_SPR_LINE 4
`endif

// ==== include/vdphp_pkg.sv ====
// Types of the video processor host port
package vdphp_pkg;
    typedef struct packed {
        logic [13:0] addr;
        logic [7:0] data;
        logic write;
    } vdphp_mem_req_t;
    typedef struct packed {
        logic frame_end;
        logic fifth;
        logic [4:0] fifth_num;
        logic collision;
    } vdphp_event_t;
    typedef enum logic [1:0] {
        VDPHP_IDLE = 2'b00,
        VDPHP_READ_WAIT = 2'b01,
        VDPHP_PREFETCH = 2'b10
    } vdphp_state_t;
endpackage

// ==== rtl/vdphp_buf2.sv ====
// Two-entry valid/ready buffer
`timescale 1ns/1ns
module vdphp_buf2 #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    logic [WIDTH-1:0] mem [0:1];
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign push = i_valid && (count != 2'd2);
    assign pop = o_valid && i_ready;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'd0;
        end else if (i_ce) begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_ce && push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_valid <= 1'b0;
            o_ready <= 1'b1;
            o_data <= '0;
        end else if (i_ce) begin
            o_valid <= (count + {1'b0, push} - {1'b0, pop}) != 2'd0;
            o_ready <= (count + {1'b0, push} - {1'b0, pop}) != 2'd2;
            if (pop || !o_valid) begin
                if (count == 2'd0) begin
                    o_data <= i_data;
                end else if (pop && count == 2'd2) begin
                    o_data <= mem[~rd_ptr];
                end else if (pop) begin
                    o_data <= i_data;
                end else begin
                    o_data <= mem[rd_ptr];
                end
            end
        end
    end
endmodule

// ==== rtl/vdphp_host_port.sv ====
// Host port of the video display processor
`timescale 1ns/1ns
`include "vdphp_regs.svh"

// Summary of operation
// - Name base low four bits give top video memory address bits.
// - Colour base holds top eight colour table address bits, mode one.
// - Pattern base low three bits give pattern table top bits.
// - Sprite attribute base low seven bits give its top bits.
// - Sprite pattern base low three bits give its top bits.
// - Text mode: upper nibble set pixels, lower nibble clear and backdrop.
// - Colours are four-bit codes; zero transparent, one black, F white.
// - Frame end with enable set drives interrupt low and sets flag.
// - Five sprites on a line with frame flag clear set fifth flag.
// - Fifth sprite plane number kept in status low five bits.
// - Overlapping opaque pixels of two sprites set collision flag.
// - Status flags stay set until reset or status read.
// - Register write: data byte, then 1,0000 and register number.
// - Data captured on write strobe rising edge.
// - Bus driven only while read strobe is low.
// - Address bytes low then 01 plus high bits; data follows.
// - Address pointer increments after every data byte; no step here for a byte met with request buffer full or prefetch pending.
// - Read setup uses 00 top bits; data returned on read strobe.
// - Only four highest-priority sprites shown per line.
module vdphp_host_port (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_write_strobe_n,
    input wire logic i_read_strobe_n,
    input wire logic i_mode,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    input wire vdphp_pkg::vdphp_event_t i_event,
    input wire logic [5:0] i_line_sprite_count,
    output logic o_irq_n,
    output logic [7:0] o_mode0,
    output logic [7:0] o_mode1,
    output logic [3:0] o_name_base,
    output logic [7:0] o_color_base,
    output logic [2:0] o_pattern_base,
    output logic [6:0] o_sprite_attr_base,
    output logic [2:0] o_sprite_pat_base,
    output logic [3:0] o_fg_colour,
    output logic [3:0] o_backdrop_colour,
    output logic [2:0] o_shown_sprites,
    output logic o_mem_req_valid,
    input wire logic i_mem_req_ready,
    output vdphp_pkg::vdphp_mem_req_t o_mem_req,
    input wire logic i_mem_rd_valid,
    input wire logic [7:0] i_mem_rd_data
);
    import vdphp_pkg::*;

    logic [2:0] wr_sync;
    logic [2:0] rd_sync;
    logic [2:0] md_sync;
    logic wr_n;
    logic rd_n;
    logic mode_q;
    logic mode_now;
    logic wr_rise;
    logic rd_fall;
    logic rd_rise;
    logic [7:0] wr_data;
    logic first_byte;
    logic [7:0] held_byte;
    logic [13:0] addr_ptr;
    logic [7:0] status;
    logic [7:0] read_latch;
    logic [7:0] mem_rd_buf;
    logic status_read;
    vdphp_state_t state;
    vdphp_state_t next_state;
    vdphp_mem_req_t buf_in;
    logic buf_in_valid;
    logic buf_in_ready;
    logic [4:0] max_shown;

    // Three-stage sampling of pins
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_sync <= 3'h7;
            rd_sync <= 3'h7;
            md_sync <= 3'h7;
        end else if (i_ce) begin
            wr_sync <= {wr_sync[1:0], i_write_strobe_n};
            rd_sync <= {rd_sync[1:0], i_read_strobe_n};
            md_sync <= {md_sync[1:0], i_mode};
        end
    end

    // Debounced levels, change once stages two and three agree
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_n <= 1'b1;
            rd_n <= 1'b1;
            mode_q <= 1'b1;
        end else if (i_ce) begin
            if (wr_sync[1] == wr_sync[2]) begin
                wr_n <= wr_sync[2];
            end
            if (rd_sync[1] == rd_sync[2]) begin
                rd_n <= rd_sync[2];
            end
            if (md_sync[1] == md_sync[2]) begin
                mode_q <= md_sync[2];
            end
        end
    end

    assign wr_rise = !wr_n && wr_sync[1] && wr_sync[2];
    assign rd_fall = rd_n && !rd_sync[1] && !rd_sync[2];
    assign rd_rise = !rd_n && rd_sync[1] && rd_sync[2];
    // Mode in step with the strobe stages: the pin may move with the strobe
    assign mode_now = (md_sync[1] == md_sync[2]) ? md_sync[2] : mode_q;

    // Data held while the strobe is low, taken at its rising edge
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_data <= 8'h00;
        end else if (i_ce && !wr_sync[2]) begin
            wr_data <= i_data;
        end
    end

    // Control port byte pairing
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            first_byte <= 1'b1;
            held_byte <= 8'h00;
        end else if (i_ce) begin
            if (wr_rise && mode_q) begin
                first_byte <= ~first_byte;
                if (first_byte) begin
                    held_byte <= wr_data;
                end
            end else if (rd_fall) begin
                first_byte <= 1'b1;
            end
        end
    end

    // Setup registers
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mode0 <= `VDPHP_REG_RESET;
            o_mode1 <= `VDPHP_REG_RESET;
            o_name_base <= 4'h0;
            o_color_base <= `VDPHP_REG_RESET;
            o_pattern_base <= 3'h0;
            o_sprite_attr_base <= 7'h00;
            o_sprite_pat_base <= 3'h0;
            o_fg_colour <= 4'h0;
            o_backdrop_colour <= 4'h0;
        end else if (i_ce && wr_rise && mode_q && !first_byte &&
                     wr_data[7] && wr_data[6:3] == 4'h0) begin
            case (wr_data[2:0])
                `VDPHP_REG_MODE0: o_mode0 <= held_byte;
                `VDPHP_REG_MODE1: o_mode1 <= held_byte;
                `VDPHP_REG_NAME: o_name_base <= held_byte[3:0];
                `VDPHP_REG_COLOR: o_color_base <= held_byte;
                `VDPHP_REG_PATTERN: o_pattern_base <= held_byte[2:0];
                `VDPHP_REG_SPR_ATTR: begin
                    o_sprite_attr_base <= held_byte[6:0];
                end
                `VDPHP_REG_SPR_PAT: o_sprite_pat_base <= held_byte[2:0];
                `VDPHP_REG_TEXT_COL: begin
                    o_fg_colour <= held_byte[7:4];
                    o_backdrop_colour <= held_byte[3:0];
                end
                default: o_mode0 <= o_mode0;
            endcase
        end
    end

    // Address pointer: set by two control bytes, steps per data write accepted in IDLE and per prefetched byte
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            addr_ptr <= 14'h0000;
        end else if (i_ce) begin
            if (wr_rise && mode_q && !first_byte && !wr_data[7]) begin
                addr_ptr <= {wr_data[5:0], held_byte};
            end else if (wr_rise && !mode_q && buf_in_ready &&
                         state == VDPHP_IDLE) begin
                addr_ptr <= addr_ptr + 14'h0001;
            end else if (state == VDPHP_READ_WAIT && i_mem_rd_valid) begin
                addr_ptr <= addr_ptr + 14'h0001;
            end
        end
    end

    // Memory access sequencer: prefetch after read setup and each data read that ends in IDLE
    always_comb begin
        next_state = state;
        buf_in_valid = 1'b0;
        buf_in.addr = addr_ptr;
        buf_in.data = wr_data;
        buf_in.write = 1'b0;
        case (state)
            VDPHP_IDLE: begin
                if (wr_rise && !mode_q) begin
                    buf_in_valid = 1'b1;
                    buf_in.write = 1'b1;
                end
            end
            VDPHP_PREFETCH: begin
                buf_in_valid = 1'b1;
                if (buf_in_ready) begin
                    next_state = VDPHP_READ_WAIT;
                end
            end
            VDPHP_READ_WAIT: begin
                if (i_mem_rd_valid) begin
                    next_state = VDPHP_IDLE;
                end
            end
            default: next_state = VDPHP_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= VDPHP_IDLE;
        end else if (i_ce) begin
            if (wr_rise && mode_q && !first_byte &&
                wr_data[7:6] == 2'b00) begin
                state <= VDPHP_PREFETCH;
            end else if (rd_rise && !mode_q && state == VDPHP_IDLE) begin
                state <= VDPHP_PREFETCH;
            end else begin
                state <= next_state;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mem_rd_buf <= 8'h00;
        end else if (i_ce && state == VDPHP_READ_WAIT && i_mem_rd_valid) begin
            mem_rd_buf <= i_mem_rd_data;
        end
    end

    vdphp_buf2 #(
        .WIDTH($bits(vdphp_mem_req_t))
    ) u_req_buf (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_valid(buf_in_valid),
        .o_ready(buf_in_ready),
        .i_data(buf_in),
        .o_valid(o_mem_req_valid),
        .i_ready(i_mem_req_ready),
        .o_data(o_mem_req)
    );

    assign status_read = rd_rise && mode_q;

    // Status flags: frame and collision events win over a clearing read; a fifth event is lost while the frame or fifth flag is set
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status <= 8'h00;
        end else if (i_ce) begin
            // Only flags the host has seen are cleared
            if (status_read) begin
                status[7:5] <= status[7:5] & ~read_latch[7:5];
            end
            if (i_event.frame_end) begin
                status[`VDPHP_ST_FRAME_BIT] <= 1'b1;
            end
            if (i_event.fifth && !status[`VDPHP_ST_FRAME_BIT] &&
                !status[`VDPHP_ST_FIFTH_BIT]) begin
                status[`VDPHP_ST_FIFTH_BIT] <= 1'b1;
                status[4:0] <= i_event.fifth_num;
            end else if (status_read && read_latch[`VDPHP_ST_FIFTH_BIT]) begin
                status[4:0] <= 5'h00;
            end
            if (i_event.collision) begin
                status[`VDPHP_ST_COLL_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_irq_n <= 1'b1;
        end else if (i_ce) begin
            // A new frame in the clearing cycle keeps the line low
            o_irq_n <= !(o_mode1[`VDPHP_IRQ_EN_BIT] &&
                         (status[`VDPHP_ST_FRAME_BIT] &&
                          !(status_read && read_latch[`VDPHP_ST_FRAME_BIT]) ||
                          i_event.frame_end));
        end
    end

    // Read data latched at strobe fall, driven while strobe is low
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            read_latch <= 8'h00;
        end else if (i_ce && rd_fall) begin
            if (mode_now) begin
                read_latch <= status;
            end else begin
                read_latch <= mem_rd_buf;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_data <= 8'h00;
            o_data_oe <= 1'b0;
        end else if (i_ce) begin
            if (!rd_fall) begin
                o_data <= read_latch;
            end else if (mode_now) begin
                o_data <= status;
            end else begin
                o_data <= mem_rd_buf;
            end
            o_data_oe <= !rd_sync[1] && !rd_sync[2] ||
                         (!rd_n && !(rd_sync[1] && rd_sync[2]));
        end
    end

    // Sprite display limit per line
    assign max_shown = 5'(`VDPHP_MAX_SPR_LINE);
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_shown_sprites <= 3'h0;
        end else if (i_ce) begin
            if (i_line_sprite_count > {1'b0, max_shown}) begin
                o_shown_sprites <= max_shown[2:0];
            end else begin
                o_shown_sprites <= i_line_sprite_count[2:0];
            end
        end
    end
endmodule

// ==== tb/vdphp_host_port_props.sv ====
// Pin-level assertions for the host port
`timescale 1ns/1ns
module vdphp_host_port_props (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_read_strobe_n,
    input wire vdphp_pkg::vdphp_event_t i_event,
    input wire logic [5:0] i_line_sprite_count,
    input wire logic o_data_oe,
    input wire logic o_irq_n,
    input wire logic [7:0] o_mode1,
    input wire logic [2:0] o_shown_sprites,
    input wire logic o_mem_req_valid,
    input wire logic i_mem_req_ready,
    input wire vdphp_pkg::vdphp_mem_req_t o_mem_req
);
    import vdphp_pkg::*;
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);
    a_irq_needs_enable: assert property (
        !o_irq_n |-> o_mode1[5] || $past(o_mode1[5]))
        else $error("interrupt low without enable");
    a_irq_on_frame: assert property (
        i_ce && i_event.frame_end && o_mode1[5] |-> ##[1:3] !o_irq_n)
        else $error("frame end gave no interrupt");
    a_irq_holds_set: assert property (
        i_read_strobe_n [*6] ##0 !o_irq_n |=> !o_irq_n || !o_mode1[5])
        else $error("interrupt dropped without status read");
    a_bus_driven_read: assert property (
        (i_ce && !i_read_strobe_n) [*6] |-> o_data_oe)
        else $error("bus not driven during read");
    a_bus_idle_free: assert property (
        (i_ce && i_read_strobe_n) [*6] |-> !o_data_oe)
        else $error("bus driven without read");
    a_bus_release: assert property (
        $rose(i_read_strobe_n) |-> ##[1:5] !o_data_oe)
        else $error("bus not released after read");
    a_sprite_cap: assert property (
        i_ce && i_line_sprite_count > 6'h04 |=> o_shown_sprites == 3'h4)
        else $error("more than four sprites shown");
    a_sprite_pass: assert property (
        i_ce && i_line_sprite_count <= 6'h04
        |=> o_shown_sprites == $past(i_line_sprite_count[2:0]))
        else $error("sprite count not passed through");
    a_req_held: assert property (
        o_mem_req_valid && !i_mem_req_ready
        |=> o_mem_req_valid && $stable(o_mem_req))
        else $error("memory request changed while stalled");
endmodule

// ==== tb/vdphp_mem_model.sv ====
// Video memory model on the far side of the request port
`timescale 1ns/1ns
module vdphp_mem_model (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_stall,
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire vdphp_pkg::vdphp_mem_req_t i_req,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data
);
    import vdphp_pkg::*;
    logic [7:0] mem [0:16383];
    logic [7:0] pend;
    logic [1:0] wait_cnt;
    assign o_req_ready = !i_stall;
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_cnt <= 2'h0;
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h5A;
        end else begin
            o_rd_valid <= 1'b0;
            // No stale value outside the return pulse
            o_rd_data <= ~o_rd_data;
            if (wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end
            if (wait_cnt == 2'h1) begin
                o_rd_valid <= 1'b1;
                o_rd_data <= pend;
            end
            if (i_req_valid && o_req_ready) begin
                if (i_req.write) begin
                    mem[i_req.addr] <= i_req.data;
                end else begin
                    pend <= mem[i_req.addr];
                    wait_cnt <= 2'h2;
                end
            end
        end
    end
endmodule

// ==== tb/tb_video_processor_host_port.sv ====
// Testbench for the video processor host port
`timescale 1ns/1ns
module tb_video_processor_host_port;
    import vdphp_pkg::*;
    typedef struct packed {
        logic [2:0] r;
        logic [7:0] v;
        logic [7:0] e;
    } vdphp_row_t;
    logic i_clk_sys, i_reset_n, i_ce, i_mode, stall;
    logic i_write_strobe_n, i_read_strobe_n, o_data_oe, o_irq_n;
    logic o_mem_req_valid, i_mem_req_ready, i_mem_rd_valid;
    logic [7:0] i_data, o_data, o_mode0, o_mode1, o_color_base;
    logic [7:0] i_mem_rd_data;
    logic [5:0] i_line_sprite_count;
    logic [3:0] o_name_base, o_fg_colour, o_backdrop_colour;
    logic [2:0] o_pattern_base, o_sprite_pat_base, o_shown_sprites;
    logic [6:0] o_sprite_attr_base;
    vdphp_event_t i_event;
    vdphp_mem_req_t o_mem_req;
    int failures, samples_checked;
    vdphp_row_t rows [10] = '{
        '{3'h0, 8'h02, 8'h02},
        '{3'h1, 8'hE0, 8'hE0},
        '{3'h2, 8'hF1, 8'h01},
        '{3'h3, 8'h1E, 8'h1E},
        '{3'h3, 8'h7F, 8'h7F},
        '{3'h4, 8'hF9, 8'h01},
        '{3'h5, 8'h8E, 8'h0E},
        '{3'h6, 8'hFF, 8'h07},
        '{3'h7, 8'h0F, 8'h0F},
        '{3'h7, 8'hF1, 8'hF1}};
    vdphp_host_port u_dut (.i_clk_sys, .i_reset_n, .i_ce,
        .i_write_strobe_n, .i_read_strobe_n, .i_mode, .i_data, .o_data,
        .o_data_oe, .i_event, .i_line_sprite_count, .o_irq_n, .o_mode0,
        .o_mode1, .o_name_base, .o_color_base, .o_pattern_base,
        .o_sprite_attr_base, .o_sprite_pat_base, .o_fg_colour,
        .o_backdrop_colour, .o_shown_sprites, .o_mem_req_valid,
        .i_mem_req_ready, .o_mem_req, .i_mem_rd_valid, .i_mem_rd_data);
    vdphp_mem_model u_mem (.i_clk_sys, .i_reset_n, .i_stall(stall),
        .i_req_valid(o_mem_req_valid), .o_req_ready(i_mem_req_ready),
        .i_req(o_mem_req), .o_rd_valid(i_mem_rd_valid),
        .o_rd_data(i_mem_rd_data));
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic chk(input bit ok, input string msg);
        samples_checked++;
        if (!ok) begin
            failures++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic m, input logic [7:0] d);
        i_mode = m;
        i_data = d;
        i_write_strobe_n = 1'b0;
        cyc(6);
        i_write_strobe_n = 1'b1;
        cyc(6);
    endtask
    task automatic rd(input logic m, input logic [7:0] e, input string msg);
        int n;
        n = 0;
        i_mode = m;
        i_read_strobe_n = 1'b0;
        while (o_data_oe !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        if (n == 20) begin
            failures++;
            report_and_stop();
        end
        cyc(3);
        chk(o_data === e, msg);
        i_read_strobe_n = 1'b1;
        cyc(6);
    endtask
    function automatic logic [7:0] view(input logic [2:0] r);
        case (r)
            3'h0: return o_mode0;
            3'h1: return o_mode1;
            3'h2: return {4'h0, o_name_base};
            3'h3: return o_color_base;
            3'h4: return {5'h00, o_pattern_base};
            3'h5: return {1'h0, o_sprite_attr_base};
            3'h6: return {5'h00, o_sprite_pat_base};
            default: return {o_fg_colour, o_backdrop_colour};
        endcase
    endfunction
    initial begin
        i_reset_n = 1'b0;
        i_ce = 1'b1;
        i_write_strobe_n = 1'b1;
        i_read_strobe_n = 1'b1;
        i_mode = 1'b1;
        i_data = 8'h00;
        i_event = '0;
        i_line_sprite_count = 6'h00;
        stall = 1'b0;
        failures = 0;
        samples_checked = 0;
        cyc(3);
        i_reset_n = 1'b1;
        chk(o_irq_n === 1'b1 && o_data_oe === 1'b0, "reset outputs");
        foreach (rows[i]) begin
            wr(1'b1, rows[i].v);
            wr(1'b1, {5'b10000, rows[i].r});
            chk(view(rows[i].r) === rows[i].e, "register value");
        end
        wr(1'b1, 8'h05);
        wr(1'b1, 8'h9A);
        chk(o_name_base === 4'h1, "bad select byte taken");
        wr(1'b1, 8'hFE);
        wr(1'b1, 8'h7F);
        stall = 1'b1;
        wr(1'b0, 8'hA1);
        wr(1'b0, 8'hA2);
        chk(o_mem_req_valid === 1'b1 && o_mem_req.addr === 14'h3FFE,
            "stalled request");
        stall = 1'b0;
        wr(1'b0, 8'hA3);
        cyc(4);
        chk(u_mem.mem[14'h3FFE] === 8'hA1 && u_mem.mem[14'h3FFF] === 8'hA2
            && u_mem.mem[0] === 8'hA3, "write stream");
        wr(1'b1, 8'hFE);
        wr(1'b1, 8'h3F);
        rd(1'b0, 8'hA1, "memory read first");
        rd(1'b0, 8'hA2, "memory read next");
        rd(1'b0, 8'hA3, "memory read wrap");
        i_event = '{1'b1, 1'b0, 5'h00, 1'b0};
        cyc(1);
        i_event = '{1'b0, 1'b1, 5'h0B, 1'b1};
        cyc(1);
        i_event = '0;
        cyc(4);
        chk(o_irq_n === 1'b0, "frame interrupt");
        rd(1'b1, 8'hA0, "status frame and collision");
        chk(o_irq_n === 1'b1, "interrupt after read");
        i_event = '{1'b0, 1'b1, 5'h0B, 1'b0};
        cyc(1);
        i_event = '0;
        rd(1'b1, 8'h4B, "status fifth sprite");
        rd(1'b1, 8'h00, "status cleared");
        i_event = '{1'b0, 1'b0, 5'h00, 1'b1};
        cyc(1);
        i_event = '0;
        rd(1'b1, 8'h20, "status collision");
        i_line_sprite_count = 6'h09;
        cyc(2);
        chk(o_shown_sprites === 3'h4, "sprite cap");
        i_line_sprite_count = 6'h03;
        cyc(2);
        chk(o_shown_sprites === 3'h3, "sprite pass");
        i_ce = 1'b0;
        wr(1'b1, 8'h0A);
        wr(1'b1, 8'h82);
        i_ce = 1'b1;
        chk(o_name_base === 4'h1, "write taken while frozen");
        i_event = '{1'b1, 1'b0, 5'h00, 1'b0};
        cyc(1);
        i_event = '0;
        cyc(4);
        i_reset_n = 1'b0;
        cyc(1);
        chk(o_irq_n === 1'b1 && o_name_base === 4'h0, "second reset");
        i_reset_n = 1'b1;
        cyc(2);
        report_and_stop();
    end
endmodule
bind vdphp_host_port vdphp_host_port_props u_props (.i_clk_sys, .i_reset_n,
    .i_ce, .i_read_strobe_n, .i_event, .i_line_sprite_count, .o_data_oe,
    .o_irq_n, .o_mode1, .o_shown_sprites, .o_mem_req_valid,
    .i_mem_req_ready, .o_mem_req);
